// ===== shared/ucrm_regs.svh
`ifndef UCRM_REGS_SVH
`define UCRM_REGS_SVH
`define UCRM_A_HOLD  4'h0
`define UCRM_A_INT_EN     4'h1
`define UCRM_A_INT_STAT   4'h2
`define UCRM_A_LINE_CTL   4'h3
`define UCRM_A_MODEM_CTL  4'h4
`define UCRM_A_LINE_STAT  4'h5
`define UCRM_A_MODEM_STAT 4'h6
`define UCRM_A_SCRATCH    4'h7
`define UCRM_A_FEATURE    4'h8
`define UCRM_A_ENHANCED   4'h9
`define UCRM_A_TXL   4'ha
`define UCRM_A_RXL   4'hb
`define UCRM_A_XCH   4'hc
`define UCRM_A_STOP2 4'hd
`define UCRM_A_RES1  4'he
`define UCRM_A_RES2  4'hf
`define UCRM_LINE_DIV   7
`define UCRM_ENH_UNLOCK 4
`define UCRM_MODEM_LOOP 4
`define UCRM_FIFO_EN    0
`define UCRM_FIFO_RXRST 1
`define UCRM_FIFO_TXRST 2
`define UCRM_RST_BYTE 8'h00
`define UCRM_RST_NIB  4'h0
`define UCRM_WL_BASE  4'h5
`endif

// ===== shared/ucrm_pkg.sv
package ucrm_pkg;
  typedef logic [7:0] ucrm_byte_t;
  typedef logic [3:0] ucrm_addr_t;
  typedef logic [3:0] ucrm_nib_t;
endpackage

// ===== logic/ucrm_channel_regs.sv
`timescale 1ns/1ps
`include "ucrm_regs.svh"
module ucrm_channel_regs (
  input  wire logic               i_mclk,
  input  wire logic               i_resetn,
  input  wire logic               i_cs,
  input  wire logic               i_rd,
  input  wire logic               i_wr,
  input  wire ucrm_pkg::ucrm_addr_t i_addr,
  input  wire ucrm_pkg::ucrm_byte_t i_wdata,
  output ucrm_pkg::ucrm_byte_t    o_rdata,
  input  wire ucrm_pkg::ucrm_byte_t i_rx_char,
  input  wire ucrm_pkg::ucrm_byte_t i_line_status,
  input  wire ucrm_pkg::ucrm_nib_t  i_modem_in,
  input  wire ucrm_pkg::ucrm_nib_t  i_modem_delta,
  input  wire ucrm_pkg::ucrm_nib_t  i_int_code,
  input  wire logic               i_flow_delta,
  input  wire logic               i_special_char,
  input  wire ucrm_pkg::ucrm_byte_t i_tx_count,
  input  wire ucrm_pkg::ucrm_byte_t i_rx_count,
  input  wire logic               i_stop_det,
  input  wire logic               i_resume_det,
  output logic                    o_tx_load,
  output ucrm_pkg::ucrm_byte_t    o_tx_char,
  output logic                    o_rx_pop,
  output logic                    o_line_read,
  output logic                    o_modem_read,
  output logic                    o_status_read,
  output logic                    o_txfifo_rst,
  output logic                    o_rxfifo_rst,
  output logic [15:0]             o_divisor,
  output ucrm_pkg::ucrm_byte_t    o_int_enable,
  output logic [1:0]              o_rx_trig_sel,
  output logic [1:0]              o_tx_trig_sel,
  output logic                    o_dma_mode,
  output logic                    o_fifo_en,
  output ucrm_pkg::ucrm_byte_t    o_line_control,
  output ucrm_pkg::ucrm_nib_t     o_data_bits,
  output ucrm_pkg::ucrm_byte_t    o_modem_control,
  output logic                    o_rts,
  output logic                    o_dtr,
  output ucrm_pkg::ucrm_nib_t     o_turnaround_delay,
  output ucrm_pkg::ucrm_byte_t    o_feature_control,
  output ucrm_pkg::ucrm_byte_t    o_enhanced_features,
  output ucrm_pkg::ucrm_byte_t    o_tx_trigger_level,
  output ucrm_pkg::ucrm_byte_t    o_rx_trigger_level,
  output ucrm_pkg::ucrm_byte_t    o_stop_char_first,
  output ucrm_pkg::ucrm_byte_t    o_stop_char_second,
  output ucrm_pkg::ucrm_byte_t    o_resume_char_first,
  output ucrm_pkg::ucrm_byte_t    o_resume_char_second
);

////////////////////////////////////////////////////////////////////////////
  ucrm_pkg::ucrm_byte_t div_low_reg;
  ucrm_pkg::ucrm_byte_t div_high_reg;
  ucrm_pkg::ucrm_byte_t int_enable_reg;
  ucrm_pkg::ucrm_byte_t fifo_control_reg;
  ucrm_pkg::ucrm_byte_t line_control_reg;
  ucrm_pkg::ucrm_byte_t modem_control_reg;
  ucrm_pkg::ucrm_nib_t  turnaround_delay_reg;
  ucrm_pkg::ucrm_byte_t scratchpad_reg;
  ucrm_pkg::ucrm_byte_t feature_control_reg;
  ucrm_pkg::ucrm_byte_t enhanced_features_reg;
  ucrm_pkg::ucrm_byte_t tx_trigger_level_reg;
  ucrm_pkg::ucrm_byte_t rx_trigger_level_reg;
  ucrm_pkg::ucrm_byte_t stop_char_first_reg;
  ucrm_pkg::ucrm_byte_t stop_char_second_reg;
  ucrm_pkg::ucrm_byte_t resume_char_first_reg;
  ucrm_pkg::ucrm_byte_t resume_char_second_reg;
  logic                 stop_flag_reg;
  logic                 resume_flag_reg;
  ucrm_pkg::ucrm_byte_t rdata_next;
  ucrm_pkg::ucrm_nib_t  modem_state;
  logic                 acc_rd;
  logic                 acc_wr;
  logic                 div_access;
  logic                 unlock;
  logic                 loop_en;
  logic                 flag_clr;

  assign acc_rd     = i_cs & i_rd;
  assign acc_wr     = i_cs & i_wr;
  assign div_access = line_control_reg[`UCRM_LINE_DIV];
  assign unlock     = enhanced_features_reg[`UCRM_ENH_UNLOCK];
  assign loop_en    = modem_control_reg[`UCRM_MODEM_LOOP];
  assign flag_clr   = acc_rd & (i_addr == `UCRM_A_XCH);

////////////////////////////////////////////////////////////////////////////
  // extended fields keep their old value while locked
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_low_reg            <= `UCRM_RST_BYTE;
      div_high_reg           <= `UCRM_RST_BYTE;
      int_enable_reg         <= `UCRM_RST_BYTE;
      fifo_control_reg       <= `UCRM_RST_BYTE;
      line_control_reg       <= `UCRM_RST_BYTE;
      modem_control_reg      <= `UCRM_RST_BYTE;
      turnaround_delay_reg   <= `UCRM_RST_NIB;
      scratchpad_reg         <= `UCRM_RST_BYTE;
      feature_control_reg    <= `UCRM_RST_BYTE;
      enhanced_features_reg  <= `UCRM_RST_BYTE;
      tx_trigger_level_reg   <= `UCRM_RST_BYTE;
      rx_trigger_level_reg   <= `UCRM_RST_BYTE;
      stop_char_first_reg    <= `UCRM_RST_BYTE;
      stop_char_second_reg   <= `UCRM_RST_BYTE;
      resume_char_first_reg  <= `UCRM_RST_BYTE;
      resume_char_second_reg <= `UCRM_RST_BYTE;
    end else if (acc_wr) begin
      unique case (i_addr)
        `UCRM_A_HOLD: begin
          if (div_access) begin
            div_low_reg <= i_wdata;
          end
        end
        `UCRM_A_INT_EN: begin
          if (div_access) begin
            div_high_reg <= i_wdata;
          end else if (unlock) begin
            int_enable_reg <= {i_wdata[7:5], 1'b0, i_wdata[3:0]};
          end else begin
            int_enable_reg <= {int_enable_reg[7:4], i_wdata[3:0]};
          end
        end
        `UCRM_A_INT_STAT: begin
          // reset bits are pulses, never stored
          fifo_control_reg <= {i_wdata[7:6],
                               unlock ? i_wdata[5:4]
                                      : fifo_control_reg[5:4],
                               i_wdata[3], 2'b00, i_wdata[0]};
        end
        `UCRM_A_LINE_CTL: line_control_reg <= i_wdata;
        `UCRM_A_MODEM_CTL: begin
          modem_control_reg <= {unlock ? i_wdata[7:5]
                                       : modem_control_reg[7:5],
                                i_wdata[4:0]};
        end
        `UCRM_A_LINE_STAT: begin
          // status comes from the core; writes have no effect
        end
        `UCRM_A_MODEM_STAT: begin
          if (unlock) begin
            turnaround_delay_reg <= i_wdata[7:4];
          end
        end
        `UCRM_A_SCRATCH: scratchpad_reg <= i_wdata;
        `UCRM_A_FEATURE: feature_control_reg <= i_wdata;
        `UCRM_A_ENHANCED: enhanced_features_reg <= i_wdata;
        `UCRM_A_TXL: tx_trigger_level_reg <= i_wdata;
        `UCRM_A_RXL: rx_trigger_level_reg <= i_wdata;
        `UCRM_A_XCH: stop_char_first_reg <= i_wdata;
        `UCRM_A_STOP2: stop_char_second_reg <= i_wdata;
        `UCRM_A_RES1: resume_char_first_reg <= i_wdata;
        `UCRM_A_RES2: resume_char_second_reg <= i_wdata;
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////////
  // side-effect strobes, one cycle after the access
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_load    <= 1'b0;
      o_tx_char    <= `UCRM_RST_BYTE;
      o_rx_pop     <= 1'b0;
      o_line_read  <= 1'b0;
      o_modem_read <= 1'b0;
      o_status_read <= 1'b0;
      o_txfifo_rst <= 1'b0;
      o_rxfifo_rst <= 1'b0;
    end else begin
      o_tx_load    <= acc_wr & (i_addr == `UCRM_A_HOLD) & ~div_access;
      o_rx_pop     <= acc_rd & (i_addr == `UCRM_A_HOLD) & ~div_access;
      o_line_read  <= acc_rd & (i_addr == `UCRM_A_LINE_STAT);
      o_modem_read <= acc_rd & (i_addr == `UCRM_A_MODEM_STAT);
      o_status_read <= acc_rd & (i_addr == `UCRM_A_INT_STAT);
      o_txfifo_rst <= acc_wr & (i_addr == `UCRM_A_INT_STAT)
                      & i_wdata[`UCRM_FIFO_TXRST];
      o_rxfifo_rst <= acc_wr & (i_addr == `UCRM_A_INT_STAT)
                      & i_wdata[`UCRM_FIFO_RXRST];
      if (acc_wr && (i_addr == `UCRM_A_HOLD) && !div_access) begin
        o_tx_char <= i_wdata;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////
  // a detection in the clearing cycle survives the read
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_flag_reg   <= 1'b0;
      resume_flag_reg <= 1'b0;
    end else begin
      stop_flag_reg   <= i_stop_det | (stop_flag_reg & ~flag_clr);
      resume_flag_reg <= i_resume_det | (resume_flag_reg & ~flag_clr);
    end
  end

////////////////////////////////////////////////////////////////////////////
  // loopback: outputs feed the four modem inputs
  assign modem_state = loop_en ?
                       {modem_control_reg[3], modem_control_reg[2],
                        modem_control_reg[0], modem_control_reg[1]}
                       : i_modem_in;

  always_comb begin
    rdata_next = `UCRM_RST_BYTE;
    unique case (i_addr)
      `UCRM_A_HOLD: rdata_next = div_access ? div_low_reg : i_rx_char;
      `UCRM_A_INT_EN: begin
        rdata_next = div_access ? div_high_reg
                   : {int_enable_reg[7:5] & {3{unlock}}, 1'b0,
                      int_enable_reg[3:0]};
      end
      `UCRM_A_INT_STAT: begin
        rdata_next = {{2{fifo_control_reg[`UCRM_FIFO_EN]}},
                      i_flow_delta & unlock, i_special_char & unlock,
                      i_int_code};
      end
      `UCRM_A_LINE_CTL:   rdata_next = line_control_reg;
      `UCRM_A_MODEM_CTL:  rdata_next = {modem_control_reg[7:5] & {3{unlock}},
                                        modem_control_reg[4:0]};
      `UCRM_A_LINE_STAT:  rdata_next = i_line_status;
      `UCRM_A_MODEM_STAT: rdata_next = {modem_state, i_modem_delta};
      `UCRM_A_SCRATCH:    rdata_next = scratchpad_reg;
      `UCRM_A_FEATURE:    rdata_next = feature_control_reg;
      `UCRM_A_ENHANCED:   rdata_next = enhanced_features_reg;
      `UCRM_A_TXL:  rdata_next = i_tx_count;
      `UCRM_A_RXL:  rdata_next = i_rx_count;
      `UCRM_A_XCH: begin
        rdata_next = {6'h00, resume_flag_reg, stop_flag_reg};
      end
      `UCRM_A_STOP2: rdata_next = `UCRM_RST_BYTE;
      `UCRM_A_RES1:  rdata_next = `UCRM_RST_BYTE;
      `UCRM_A_RES2:  rdata_next = `UCRM_RST_BYTE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `UCRM_RST_BYTE;
    end else if (acc_rd) begin
      o_rdata <= rdata_next;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // locked extended bits are masked so stale values cannot act
  assign o_divisor            = {div_high_reg, div_low_reg};
  assign o_int_enable         = {int_enable_reg[7:5] & {3{unlock}}, 1'b0,
                                 int_enable_reg[3:0]};
  assign o_rx_trig_sel        = fifo_control_reg[7:6];
  assign o_tx_trig_sel        = fifo_control_reg[5:4] & {2{unlock}};
  assign o_dma_mode           = fifo_control_reg[3];
  assign o_fifo_en            = fifo_control_reg[`UCRM_FIFO_EN];
  assign o_line_control       = line_control_reg;
  assign o_data_bits          = `UCRM_WL_BASE
                                + {2'b00, line_control_reg[1:0]};
  // general outputs stay internal: no pin carries them
  assign o_modem_control      = {modem_control_reg[7:5] & {3{unlock}},
                                 modem_control_reg[4], 2'b00,
                                 modem_control_reg[1:0]};
  // loopback keeps the line pins from following the register
  assign o_rts                = modem_control_reg[1] & ~loop_en;
  assign o_dtr                = modem_control_reg[0] & ~loop_en;
  assign o_turnaround_delay   = turnaround_delay_reg & {4{unlock}};
  assign o_feature_control    = feature_control_reg;
  assign o_enhanced_features  = enhanced_features_reg;
  assign o_tx_trigger_level   = tx_trigger_level_reg;
  assign o_rx_trigger_level   = rx_trigger_level_reg;
  assign o_stop_char_first    = stop_char_first_reg;
  assign o_stop_char_second   = stop_char_second_reg;
  assign o_resume_char_first  = resume_char_first_reg;
  assign o_resume_char_second = resume_char_second_reg;

////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  property p_tx_load;
    acc_wr && i_addr == `UCRM_A_HOLD && !div_access
      |=> o_tx_load && o_tx_char == $past(i_wdata) ##1
          (!o_tx_load
           || $past(acc_wr && i_addr == `UCRM_A_HOLD && !div_access));
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("character write did not load transmitter");

  property p_div_write;
    acc_wr && i_addr == `UCRM_A_HOLD && div_access
      |=> o_divisor[7:0] == $past(i_wdata) && !o_tx_load;
  endproperty
  a_div_write: assert property (p_div_write)
    else $error("divisor low byte write failed");

  property p_enable_bit4;
    acc_rd && i_addr == `UCRM_A_INT_EN && !div_access |=> !o_rdata[4];
  endproperty
  a_enable_bit4: assert property (p_enable_bit4)
    else $error("reserved enable bit read as one");

  property p_status_read;
    acc_rd && i_addr == `UCRM_A_INT_STAT
      |=> o_status_read && o_rdata[7:6] == {2{$past(o_fifo_en)}};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read lost fifo enable bits");

  property p_fifo_rst;
    acc_wr && i_addr == `UCRM_A_INT_STAT && i_wdata[`UCRM_FIFO_RXRST]
      |=> o_rxfifo_rst ##1 (!o_rxfifo_rst || $past(acc_wr
          && i_addr == `UCRM_A_INT_STAT && i_wdata[`UCRM_FIFO_RXRST]));
  endproperty
  a_fifo_rst: assert property (p_fifo_rst)
    else $error("receive fifo reset not a single pulse");

  property p_locked;
    acc_wr && i_addr == `UCRM_A_INT_EN && !div_access && !unlock
      |=> $stable(int_enable_reg[7:5]);
  endproperty
  a_locked: assert property (p_locked)
    else $error("extended enable bits changed while locked");

  property p_flag_clear;
    flag_clr && !i_stop_det |=> !stop_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("stop flag did not clear on read");

  property p_flag_set;
    i_stop_det |=> stop_flag_reg [*1] ##1 (stop_flag_reg || $past(flag_clr));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("stop detection lost");

  property p_char_write;
    acc_wr && i_addr == `UCRM_A_XCH
      |=> o_stop_char_first == $past(i_wdata);
  endproperty
  a_char_write: assert property (p_char_write)
    else $error("first stop character not loaded");

  property p_loopback;
    loop_en && acc_rd && i_addr == `UCRM_A_MODEM_STAT
      |=> o_rdata[7:6] == $past(modem_control_reg[3:2]);
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("general outputs not seen in loopback");

  property p_word_len;
    acc_wr && i_addr == `UCRM_A_LINE_CTL
      |=> o_data_bits == `UCRM_WL_BASE + {2'b00, $past(i_wdata[1:0])};
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("word length decode wrong");

  c_tx: cover property (o_tx_load ##1 o_tx_load);
  c_unlock_enable: cover property (unlock && acc_wr
                                   && i_addr == `UCRM_A_INT_EN);
  c_set_clear: cover property (i_stop_det && flag_clr);
  c_loop_read: cover property (loop_en && o_modem_read);

endmodule // ucrm_channel_regs

// ===== tb/ucrm_host_model.sv
`timescale 1ns/1ps
module ucrm_host_model (
  input  wire logic                 i_mclk,
  input  wire ucrm_pkg::ucrm_byte_t i_rdata,
  output logic                      o_cs,
  output logic                      o_rd,
  output logic                      o_wr,
  output ucrm_pkg::ucrm_addr_t      o_addr,
  output ucrm_pkg::ucrm_byte_t      o_wdata
);
  initial begin
    o_cs = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 4'h0;
    o_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // called just after an edge; request held through the taking edge,
  // so consecutive calls give back-to-back accesses
  task automatic bus_op(input logic w, input ucrm_pkg::ucrm_addr_t a,
                        input ucrm_pkg::ucrm_byte_t d,
                        output ucrm_pkg::ucrm_byte_t q);
    o_cs = 1'b1;
    o_wr = w;
    o_rd = ~w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    q = i_rdata;
  endtask
  // released bus: address and data scrambled, not left at old values
  task automatic idle();
    o_cs = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
    @(posedge i_mclk);
    #1;
  endtask
endmodule // ucrm_host_model

// ===== tb/uart_channel_register_map_tb_top.sv
`timescale 1ns/1ps
module uart_channel_register_map_tb_top;
  logic mclk, resetn, cs, rd, wr, stop_det, resume_det, flow_delta;
  logic special_char, tx_load, rx_pop, line_read, modem_read, status_read;
  logic txfifo_rst, rxfifo_rst, dma_mode, fifo_en, rts, dtr;
  logic [15:0] divisor;
  logic [1:0]  rx_trig_sel, tx_trig_sel, flg;
  ucrm_pkg::ucrm_addr_t addr;
  ucrm_pkg::ucrm_nib_t  modem_in, modem_delta, int_code, data_bits, tdelay;
  ucrm_pkg::ucrm_nib_t  turnaround_delay;
  ucrm_pkg::ucrm_byte_t wdata, rdata, rx_char, line_status, tx_count;
  ucrm_pkg::ucrm_byte_t rx_count, tx_char, int_enable, line_control;
  ucrm_pkg::ucrm_byte_t modem_control, feature_control, enhanced_features;
  ucrm_pkg::ucrm_byte_t tx_trigger_level, rx_trigger_level, stop_char_first;
  ucrm_pkg::ucrm_byte_t stop_char_second, resume_char_first;
  ucrm_pkg::ucrm_byte_t resume_char_second, div_lo, div_hi;
  logic [7:0] mr [16];
  int error_cnt, checks;
  logic [31:0] r;

  ucrm_host_model host (.i_mclk(mclk), .i_rdata(rdata), .o_cs(cs),
    .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));

  ucrm_channel_regs dut (.i_mclk(mclk), .i_resetn(resetn), .i_cs(cs),
    .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .i_rx_char(rx_char), .i_line_status(line_status),
    .i_modem_in(modem_in), .i_modem_delta(modem_delta),
    .i_int_code(int_code), .i_flow_delta(flow_delta),
    .i_special_char(special_char), .i_tx_count(tx_count),
    .i_rx_count(rx_count), .i_stop_det(stop_det),
    .i_resume_det(resume_det), .o_tx_load(tx_load), .o_tx_char(tx_char),
    .o_rx_pop(rx_pop), .o_line_read(line_read), .o_modem_read(modem_read),
    .o_status_read(status_read), .o_txfifo_rst(txfifo_rst),
    .o_rxfifo_rst(rxfifo_rst), .o_divisor(divisor),
    .o_int_enable(int_enable), .o_rx_trig_sel(rx_trig_sel),
    .o_tx_trig_sel(tx_trig_sel), .o_dma_mode(dma_mode), .o_fifo_en(fifo_en),
    .o_line_control(line_control), .o_data_bits(data_bits),
    .o_modem_control(modem_control), .o_rts(rts), .o_dtr(dtr),
    .o_turnaround_delay(turnaround_delay),
    .o_feature_control(feature_control),
    .o_enhanced_features(enhanced_features),
    .o_tx_trigger_level(tx_trigger_level),
    .o_rx_trigger_level(rx_trigger_level),
    .o_stop_char_first(stop_char_first),
    .o_stop_char_second(stop_char_second),
    .o_resume_char_first(resume_char_first),
    .o_resume_char_second(resume_char_second));

  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // model: locked writes leave the extended bits as they were
  task automatic mdl_wr(logic [3:0] a, logic [7:0] d);
    logic u;
    u = mr[9][4];
    case (a)
      4'h0: if (mr[3][7]) div_lo = d;
      4'h1: if (mr[3][7]) div_hi = d;
        else mr[1] = u ? d : {mr[1][7:4], d[3:0]};
      4'h2: mr[2] = u ? d : {d[7:6], mr[2][5:4], d[3:0]};
      4'h4: mr[4] = u ? d : {mr[4][7:5], d[4:0]};
      4'h5: ;
      4'h6: if (u) tdelay = d[7:4];
      default: mr[a] = d;
    endcase
  endtask

  function automatic logic [7:0] mdl_rd(logic [3:0] a);
    logic u;
    logic [7:0] v;
    u = mr[9][4];
    case (a)
      4'h0: v = mr[3][7] ? div_lo : rx_char;
      4'h1: v = mr[3][7] ? div_hi : mr[1] & (u ? 8'hef : 8'h0f);
      4'h2: v = {{2{mr[2][0]}}, u & flow_delta, u & special_char, int_code};
      4'h4: v = mr[4] & (u ? 8'hff : 8'h1f);
      4'h5: v = line_status;
      4'h6: v = {mr[4][4] ? {mr[4][3:2], mr[4][0], mr[4][1]} : modem_in,
                 modem_delta};
      4'ha: v = tx_count;
      4'hb: v = rx_count;
      4'hc: v = {6'h00, flg};
      4'hd, 4'he, 4'hf: v = 8'h00;
      default: v = mr[a];
    endcase
    return v;
  endfunction

  task automatic check_outs();
    logic u;
    u = mr[9][4];
    chk("divisor", divisor, {div_hi, div_lo});
    chk("int_enable", int_enable, mr[1] & (u ? 8'hef : 8'h0f));
    chk("rx_trig_sel", rx_trig_sel, mr[2][7:6]);
    chk("tx_trig_sel", tx_trig_sel, u ? mr[2][5:4] : 2'h0);
    chk("dma_mode", dma_mode, mr[2][3]);
    chk("fifo_en", fifo_en, mr[2][0]);
    chk("line_control", line_control, mr[3]);
    chk("data_bits", data_bits, 4'h5 + {2'h0, mr[3][1:0]});
    chk("modem_control", modem_control, mr[4] & (u ? 8'hf3 : 8'h13));
    chk("rts", rts, mr[4][1] & ~mr[4][4]);
    chk("dtr", dtr, mr[4][0] & ~mr[4][4]);
    chk("turnaround", turnaround_delay, u ? tdelay : 4'h0);
    chk("feature", feature_control, mr[8]);
    chk("enhanced", enhanced_features, mr[9]);
    chk("tx_trigger", tx_trigger_level, mr[10]);
    chk("rx_trigger", rx_trigger_level, mr[11]);
    chk("stop_first", stop_char_first, mr[12]);
    chk("stop_second", stop_char_second, mr[13]);
    chk("resume_first", resume_char_first, mr[14]);
    chk("resume_second", resume_char_second, mr[15]);
  endtask

  task automatic do_op(logic w, logic [3:0] a, logic [7:0] d);
    logic [7:0] q, e;
    logic hold, lb;
    e = mdl_rd(a);
    hold = (a == 4'h0) && !mr[3][7];
    lb = mr[4][4];
    host.bus_op(w, a, d, q);
    if (w) begin
      chk("tx_load", tx_load, hold);
      if (hold) chk("tx_char", tx_char, d);
      chk("txfifo_rst", txfifo_rst, a == 4'h2 && d[2]);
      chk("rxfifo_rst", rxfifo_rst, a == 4'h2 && d[1]);
      mdl_wr(a, d);
      check_outs();
    end else begin
      if (a == 4'h6 && lb) chk("rdata", q, e);
      else chk("rdata", q, e);
      chk("rx_pop", rx_pop, hold);
      chk("line_read", line_read, a == 4'h5);
      chk("modem_read", modem_read, a == 4'h6);
      chk("status_read", status_read, a == 4'h2);
      if (a == 4'hc) flg = 2'h0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    close_out();
  end

  initial begin
    r = $urandom(32'h8fc7);
    mclk = 1'b0;
    resetn = 1'b0;
    {rx_char, line_status, tx_count, rx_count} = 32'h0000_0000;
    {modem_in, modem_delta, int_code} = 12'h000;
    {flow_delta, special_char, stop_det, resume_det} = 4'h0;
    foreach (mr[i]) mr[i] = 8'h00;
    {div_lo, div_hi, tdelay, flg} = 22'h00_0000;
    error_cnt = 0;
    checks = 0;
    repeat (8) @(posedge mclk);
    #1;
    resetn = 1'b1;
    chk("rdata", rdata, 8'h00);
    check_outs();
    // every length code, back to back
    for (int k = 0; k < 4; k++) do_op(1'b1, 4'h3, 8'(k));
    // flag set by detect pulses, gone after one read
    for (int k = 1; k < 4; k++) begin
      stop_det = k[0];
      resume_det = k[1];
      host.idle();
      stop_det = 1'b0;
      resume_det = 1'b0;
      flg = k[1:0];
      do_op(1'b0, 4'hc, 8'h00);
      do_op(1'b0, 4'hc, 8'h00);
    end
    // detect in the clearing read: set wins
    stop_det = 1'b1;
    do_op(1'b0, 4'hc, 8'h00);
    stop_det = 1'b0;
    flg = 2'h1;
    do_op(1'b0, 4'hc, 8'h00);
    // random mix of locked and unlocked, divisor access on and off
    repeat (600) begin
      {rx_char, line_status, tx_count, rx_count} = $urandom;
      r = $urandom;
      {modem_in, modem_delta, int_code, flow_delta, special_char} = r[13:0];
      r = $urandom;
      if (r[4:3] == 2'h0) host.idle();
      do_op(r[0], r[11:8], r[19:12]);
    end
    host.idle();
    close_out();
  end
endmodule // uart_channel_register_map_tb_top
